/* low_power_wakeup_control.v */
// low power wake-up control: wait/stop exit, clock gating, pll config lock
//
// How it works
// - wait exits on reset, nmi, irq 0-63
// - stop bit clear: peripheral irqs wake wait
// - stop bit set: gate peripheral-source clocks in wait
// - independent-clock peripherals still wake wait
// - resume on the clock selected at wait
// - stop mode halts all unprotected clocks
// - stop exits on reset, nmi, lvd, irq 0-63 of independent-clock peripherals
// - ext interrupts six-eight wake via intelligent io
// - intelligent io wake inputs: falling edge only
// - pll multiplier config writable once per reset
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "wakeup_regs.vh"
module low_power_wakeup_control #(
  parameter IRQ_N = 64,
  parameter CLKSEL_W = 3
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // wake sources from pins and other domains
  input wire nmi_n,
  input wire lvd_irq,
  input wire ext_interrupt_six,
  input wire ext_interrupt_seven,
  input wire ext_interrupt_eight,
  // peripheral requests, already on this clock
  input wire [IRQ_N-1:0] periph_irq,
  // peripherals on clocks independent of the peripheral source
  input wire [IRQ_N-1:0] periph_independent,
  // intelligent io assignment of ext interrupts six to eight
  input wire [2:0] iio_assign,
  // pll status from the clock generator
  input wire pll_locked,
  // to clock generator and core
  output reg wake_request,
  output reg [`GATE_W-1:0] clock_run,
  output reg [CLKSEL_W-1:0] cpu_clock_select,
  output reg [1:0] power_mode,
  output reg [2:0] intelligent_io_request,
  output reg [31:0] pll_multiplier_config,
  output reg irq
);
  // protected clocks keep running in stop mode; arbitrary default
  localparam [`GATE_W-1:0] PROTECTED = 8'h00;

  reg periph_clock_stop_in_wait;
  reg [CLKSEL_W-1:0] clksel_req;
  reg [CLKSEL_W-1:0] clksel_saved;
  reg [`IRQ_W-1:0] status;
  reg [`IRQ_W-1:0] mask;
  reg [IRQ_N-1:0] wake_enable;
  reg pll_written;
  reg [1:0] next_mode;
  wire nmi_s;
  wire lvd_s;
  wire pll_s;
  wire [2:0] iio_fall;

  sync_level u_nmi (
    .clk(clk),
    .rst(rst),
    .d(~nmi_n),
    .q(nmi_s)
  );
  sync_level u_lvd (
    .clk(clk),
    .rst(rst),
    .d(lvd_irq),
    .q(lvd_s)
  );
  sync_level u_pll (
    .clk(clk),
    .rst(rst),
    .d(pll_locked),
    .q(pll_s)
  );
  sync_falling_edge u_ext_interrupt_six (
    .clk(clk),
    .rst(rst),
    .pin_n(ext_interrupt_six),
    .fall(iio_fall[0])
  );
  sync_falling_edge u_ext_interrupt_seven (
    .clk(clk),
    .rst(rst),
    .pin_n(ext_interrupt_seven),
    .fall(iio_fall[1])
  );
  sync_falling_edge u_ext_interrupt_eight (
    .clk(clk),
    .rst(rst),
    .pin_n(ext_interrupt_eight),
    .fall(iio_fall[2])
  );

  // apb decode
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit = (paddr == `REG_CTRL) | (paddr == `REG_STATUS) | (paddr == `REG_MASK) |
             (paddr == `REG_PLL) | (paddr == `REG_WAKE_EN) |
             (paddr == `REG_WAKE_EN_HI) | (paddr == `REG_CLKGATE);
  wire wr_ctrl = wr & (paddr == `REG_CTRL);

  // peripheral wake: requesting source whose wake_enable bit is set
  wire [IRQ_N-1:0] reqs = periph_irq & wake_enable;
  // gated source clock blocks wake unless peripheral runs on its own clock
  wire [IRQ_N-1:0] wait_capable = periph_clock_stop_in_wait ?
                                   periph_independent : {IRQ_N{1'b1}};
  wire periph_wait_wake = |(reqs & wait_capable);
  // stop mode keeps only independent peripheral clocks alive
  wire periph_stop_wake = |(reqs & periph_independent);
  wire [2:0] iio_wake = iio_fall & iio_assign;
  wire wait_wake = nmi_s | periph_wait_wake | (|iio_wake);
  wire stop_wake = nmi_s | lvd_s | periph_stop_wake | (|iio_wake);

  // power mode sequencer
  always @* begin
    next_mode = power_mode;
    case (power_mode)
      `MODE_RUN: begin
        if (wr_ctrl & pwdata[`CTRL_STOP_CMD])
          next_mode = `MODE_STOP;
        else if (wr_ctrl & pwdata[`CTRL_WAIT_CMD])
          next_mode = `MODE_WAIT;
      end
      `MODE_WAIT: begin
        if (wait_wake)
          next_mode = `MODE_RUN;
      end
      `MODE_STOP: begin
        if (stop_wake)
          next_mode = `MODE_RUN;
      end
      default: next_mode = `MODE_RUN;
    endcase
  end

  wire entering = (power_mode == `MODE_RUN) & (next_mode != `MODE_RUN);
  wire waking = (power_mode != `MODE_RUN) & (next_mode == `MODE_RUN);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      power_mode <= `MODE_RUN;
      wake_request <= 1'b0;
      clksel_saved <= `CLKSEL_RESET;
      cpu_clock_select <= `CLKSEL_RESET;
      clock_run <= {`GATE_W{1'b1}};
      intelligent_io_request <= 3'h0;
    end else begin
      power_mode <= next_mode;
      // one-cycle pulse so the clock generator restarts halted clocks
      wake_request <= waking;
      if (entering)
        clksel_saved <= clksel_req;
      // core restarts on the clock it was using when it slept
      if (waking)
        cpu_clock_select <= clksel_saved;
      else if (power_mode == `MODE_RUN && !entering)
        cpu_clock_select <= clksel_req;
      if (next_mode == `MODE_STOP) begin
        clock_run <= PROTECTED;
      end else if (next_mode == `MODE_WAIT && periph_clock_stop_in_wait) begin
        clock_run <= {`GATE_W{1'b1}};
        clock_run[`GATE_DIV1] <= 1'b0;
        clock_run[`GATE_DIV8] <= 1'b0;
        clock_run[`GATE_DIV32] <= 1'b0;
        clock_run[`GATE_CONV] <= 1'b0;
        clock_run[`GATE_PRE2N] <= 1'b0;
      end else begin
        clock_run <= {`GATE_W{1'b1}};
      end
      intelligent_io_request <= intelligent_io_request | iio_wake;
      if (wr & (paddr == `REG_CLKGATE))
        intelligent_io_request <= (intelligent_io_request & ~pwdata[2:0]) | iio_wake;
    end
  end

  // registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      periph_clock_stop_in_wait <= 1'b0;
      clksel_req <= `CLKSEL_RESET;
      mask <= {`IRQ_W{1'b0}};
      wake_enable <= {IRQ_N{1'b0}};
      pll_multiplier_config <= `PLL_RESET;
      pll_written <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        periph_clock_stop_in_wait <= pwdata[`CTRL_STOP_BIT];
        clksel_req <= pwdata[`CTRL_CLKSEL_LSB +: CLKSEL_W];
      end
      // a wake restores the saved selection so run mode keeps using it
      if (waking)
        clksel_req <= clksel_saved;
      if (wr & (paddr == `REG_MASK))
        mask <= pwdata[`IRQ_W-1:0];
      if (wr & (paddr == `REG_WAKE_EN))
        wake_enable[31:0] <= pwdata;
      if (wr & (paddr == `REG_WAKE_EN_HI))
        wake_enable[63:32] <= pwdata;
      // first write after reset sticks, later ones are dropped
      if (wr & (paddr == `REG_PLL) & ~pll_written) begin
        pll_multiplier_config <= pwdata;
        pll_written <= 1'b1;
      end
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  wire [`IRQ_W-1:0] events = {pll_s, |iio_wake, periph_wait_wake | periph_stop_wake,
                              lvd_s, nmi_s, waking};
  wire [`IRQ_W-1:0] clr = (wr & (paddr == `REG_STATUS)) ? pwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= {`IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      status <= (status & ~clr) | events;
      // lock flag tells software the pll may be selected
      irq <= |(((status & ~clr) | events) & mask);
    end
  end

  // apb read and response: zero wait states
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `REG_CTRL: prdata <= {24'h000000, 1'b0, clksel_req, 3'h0,
                               periph_clock_stop_in_wait};
          `REG_STATUS: prdata <= {26'h0000000, status};
          `REG_MASK: prdata <= {26'h0000000, mask};
          `REG_PLL: prdata <= pll_multiplier_config;
          `REG_WAKE_EN: prdata <= wake_enable[31:0];
          `REG_WAKE_EN_HI: prdata <= wake_enable[63:32];
          `REG_CLKGATE: prdata <= {14'h0000, power_mode, 5'h00, intelligent_io_request,
                                  pll_written, 7'h00};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // low_power_wakeup_control

/* wakeup_regs.vh */
// register map and constants for the low power wake-up control block
`ifndef WAKEUP_REGS_VH
`define WAKEUP_REGS_VH
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_MASK 12'h008
`define REG_PLL 12'h00c
`define REG_WAKE_EN 12'h010
`define REG_WAKE_EN_HI 12'h014
`define REG_CLKGATE 12'h018
`define CTRL_STOP_BIT 0
`define CTRL_WAIT_CMD 1
`define CTRL_STOP_CMD 2
`define CTRL_CLKSEL_LSB 4
`define CTRL_CLKSEL_W 3
`define ST_WAKE 0
`define ST_NMI 1
`define ST_LVD 2
`define ST_PERIPH 3
`define ST_IIO 4
`define ST_PLL_LOCKED 5
`define IRQ_W 6
`define MODE_RUN 2'h0
`define MODE_WAIT 2'h1
`define MODE_STOP 2'h2
`define PLL_RESET 32'h00000000
`define CLKSEL_RESET 3'h0
`define GATE_DIV1 0
`define GATE_DIV8 1
`define GATE_DIV32 2
`define GATE_CONV 3
`define GATE_PRE2N 4
`define GATE_LS32 5
`define GATE_EXT 6
`define GATE_PRE2N_MAIN 7
`define GATE_W 8
`endif

/* sync_falling_edge.v */
// two-flop synchroniser with falling-edge detector for one wake pin
`timescale 1ns/100ps
module sync_falling_edge (
  // clock and reset
  input wire clk,
  input wire rst,
  // pin and pulse
  input wire pin_n,
  output reg fall
);
  reg meta;
  reg sync;
  reg last;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b1;
      sync <= 1'b1;
      last <= 1'b1;
      fall <= 1'b0;
    end else begin
      meta <= pin_n;
      sync <= meta;
      last <= sync;
      // only the falling edge counts, polarity and level bits do not apply
      fall <= last & ~sync;
    end
  end
endmodule // sync_falling_edge

/* sync_level.v */
// two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module sync_level (
  // clock and reset
  input wire clk,
  input wire rst,
  // level in and out
  input wire d,
  output reg q
);
  reg meta;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sync_level

/* wakeup_checker.sv */
// port-level checks for the wake-up control block
`timescale 1ns/100ps
`include "wakeup_regs.vh"
module wakeup_checker (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // power control
  input wire wake_request,
  input wire [`GATE_W-1:0] clock_run,
  input wire [1:0] power_mode,
  input wire [31:0] pll_multiplier_config
);
  logic pll_seen;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a first write may keep the value, so only a visible change arms the lock check
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_seen <= 1'b0;
    end else if ($changed(pll_multiplier_config)) begin
      pll_seen <= 1'b1;
    end
  end
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_stop_enter: assert property (psel && penable && pwrite && paddr == `REG_CTRL
    && pwdata[`CTRL_STOP_CMD] && power_mode == `MODE_RUN |-> ##[1:2] power_mode == `MODE_STOP)
    else $error("stop not entered");
  a_stop_gated: assert property ((power_mode == `MODE_STOP)[*3] |-> clock_run == 8'h00)
    else $error("clock runs in stop");
  a_exit_wakes: assert property (power_mode == `MODE_RUN
    && $past(power_mode) != `MODE_RUN |-> ##[0:1] wake_request)
    else $error("exit without wake");
  a_wake_single: assert property (wake_request |=> !wake_request)
    else $error("wake held");
  a_pll_once: assert property (pll_seen |-> $stable(pll_multiplier_config))
    else $error("pll config rewritten");
endmodule // wakeup_checker
bind low_power_wakeup_control wakeup_checker chk (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .wake_request, .clock_run, .power_mode, .pll_multiplier_config);

/* wake_source_model.sv */
// far-side stand-in: peripheral requests and pll lock
`timescale 1ns/100ps
module wake_source_model (
  // clock and reset
  input wire clk,
  input wire rst,
  // bench command, block answer
  input wire kick,
  input wire [5:0] kick_idx,
  input wire wake_request,
  // to block
  output logic [63:0] periph_irq,
  output logic pll_locked
);
  logic [4:0] cnt;
  // level held until serviced, as a real source would
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      periph_irq <= 64'h0;
      cnt <= 5'h0;
      pll_locked <= 1'b0;
    end else begin
      if (kick) begin
        periph_irq[kick_idx] <= 1'b1;
      end else if (wake_request) begin
        periph_irq <= 64'h0;
      end
      cnt <= cnt + 5'h1;
      pll_locked <= pll_locked | (cnt == 5'h1f);
    end
  end
endmodule // wake_source_model

/* low_power_wakeup_control_bench.sv */
// testbench for the low power wake-up control block
`timescale 1ns/100ps
`include "wakeup_regs.vh"
module low_power_wakeup_control_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, kick = 1'b0, nmi_n = 1'b1, lvd_irq = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, pll_multiplier_config;
  logic pready, pslverr, er, woke, wake_request, pll_locked, irq;
  logic [2:0] pins = 3'h7, iio_assign = 3'h7, intelligent_io_request, cpu_clock_select;
  logic [5:0] kick_idx = 6'h00;
  logic [63:0] periph_irq, periph_independent = 64'h80;
  logic [7:0] clock_run;
  logic [1:0] power_mode;
  int err_count = 0, n_checks = 0, cycles = 0;
  always #20 clk = ~clk;
  low_power_wakeup_control dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .nmi_n, .lvd_irq, .ext_interrupt_six(pins[0]),
    .ext_interrupt_seven(pins[1]), .ext_interrupt_eight(pins[2]), .periph_irq,
    .periph_independent, .iio_assign, .pll_locked, .wake_request, .clock_run,
    .cpu_clock_select, .power_mode, .intelligent_io_request, .pll_multiplier_config, .irq);
  wake_source_model far (.clk, .rst, .kick, .kick_idx, .wake_request, .periph_irq, .pll_locked);
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // a pulse is only one cycle wide, so every edge is looked at
  task wt(input int lim);
    woke = 1'b0;
    for (int i = 0; i < lim && !woke; i++) begin
      @(posedge clk);
      woke = (wake_request === 1'b1);
    end
  endtask
  task poke(input logic [5:0] i);
    kick <= 1'b1;
    kick_idx <= i;
    @(posedge clk);
    kick <= 1'b0;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done;
    end
  end
  initial begin
    cyc(10);
    rst <= 1'b0;
    chk(clock_run, 8'hff);
    chk(power_mode, `MODE_RUN);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, `REG_PLL, 32'h15);
    apb(1'b1, `REG_PLL, 32'h2a);
    apb(1'b0, `REG_PLL, 32'h0);
    chk(rd, 32'h15);
    chk(pll_multiplier_config, 32'h15);
    apb(1'b1, `REG_WAKE_EN, 32'hffffffff);
    apb(1'b1, `REG_WAKE_EN_HI, 32'hffffffff);
    apb(1'b1, `REG_MASK, 32'h1f);
    apb(1'b1, `REG_CTRL, 32'h30);
    apb(1'b1, `REG_CTRL, 32'h32);
    chk(power_mode, `MODE_WAIT);
    // a new selection written while asleep must not replace the saved one
    apb(1'b1, `REG_CTRL, 32'h52);
    poke(6'h3f);
    wt(20);
    chk(woke, 1'b1);
    cyc(2);
    chk(cpu_clock_select, 3'h3);
    chk(irq, 1'b1);
    apb(1'b1, `REG_MASK, 32'h0);
    // irq is registered one edge after the mask lands
    cyc(1);
    chk(irq, 1'b0);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(rd[3:0], 4'h9);
    apb(1'b1, `REG_MASK, 32'h1f);
    apb(1'b1, `REG_STATUS, 32'h1f);
    cyc(2);
    chk(irq, 1'b0);
    chk(pll_locked, 1'b1);
    // stop bit set: source clocks gated, only independent peripherals wake
    apb(1'b1, `REG_CTRL, 32'h33);
    poke(6'h05);
    wt(20);
    chk(woke, 1'b0);
    chk(clock_run, 8'he0);
    poke(6'h07);
    wt(20);
    chk(woke, 1'b1);
    apb(1'b1, `REG_CTRL, 32'h32);
    nmi_n <= 1'b0;
    wt(20);
    chk(woke, 1'b1);
    nmi_n <= 1'b1;
    apb(1'b1, `REG_CTRL, 32'h4);
    cyc(4);
    chk(clock_run, 8'h00);
    lvd_irq <= 1'b1;
    wt(20);
    chk(woke, 1'b1);
    lvd_irq <= 1'b0;
    apb(1'b1, `REG_CTRL, 32'h4);
    nmi_n <= 1'b0;
    wt(20);
    chk(woke, 1'b1);
    nmi_n <= 1'b1;
    apb(1'b1, `REG_CTRL, 32'h4);
    poke(6'h07);
    wt(20);
    chk(woke, 1'b1);
    for (int i = 0; i < 3; i++) begin
      pins[i] <= 1'b0;
      cyc(4);
      apb(1'b1, `REG_CLKGATE, 32'h7);
      apb(1'b1, `REG_CTRL, 32'h4);
      pins[i] <= 1'b1;
      wt(20);
      chk(woke, 1'b0);
      pins[i] <= 1'b0;
      wt(20);
      chk(woke, 1'b1);
      chk(intelligent_io_request, 32'h1 << i);
      pins[i] <= 1'b1;
      cyc(4);
    end
    // a fresh reset opens the pll config for one more write
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    chk(clock_run, 8'hff);
    chk(pll_multiplier_config, 32'h0);
    apb(1'b1, `REG_PLL, 32'h2a);
    chk(pll_multiplier_config, 32'h2a);
    test_done;
  end
endmodule // low_power_wakeup_control_bench
